// File: rtl/asc_adc_sar_control.sv
// control logic of a 10-bit successive-approximation converter behind an APB slave
//
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps

module asc_adc_sar_control
   import asc_pkg::*;
(
   input  wire logic                              pclk,
   input  wire logic                              presetn,
   input  wire logic                              psel,
   input  wire logic                              penable,
   input  wire logic                              pwrite,
   input  wire logic [asc_pkg::ASC_ADDR_W-1:0]    paddr,
   input  wire logic [asc_pkg::ASC_DATA_W-1:0]    pwdata,
   output logic      [asc_pkg::ASC_DATA_W-1:0]    prdata,
   output logic                                   pready,
   output logic                                   pslverr,
   input  wire logic                              comp_above,
   input  wire logic                              rc_tad_tick,
   input  wire logic                              sleep_mode,
   input  wire logic [asc_pkg::ASC_PIN_N-1:0]     port_pin_level,
   output logic                                   converter_power_on,
   output logic      [2:0]                        input_channel_select,
   output logic                                   sample_hold_en,
   output logic      [asc_pkg::ASC_RES_W-1:0]     sar_trial_code,
   output logic                                   vref_pos_from_pin,
   output logic                                   vref_neg_from_pin,
   output logic      [asc_pkg::ASC_PIN_N-1:0]     pin_analog_mask,
   output logic                                   conversion_busy,
   output logic                                   conversion_done_flag
);
   import asc_pkg::*;

   // ========================================================================
   // decoders
   function automatic logic [ASC_DIV_W-1:0] asc_div_last(input logic hi, input logic [1:0] lo);
      logic [ASC_DIV_W-1:0] r;
      r = ASC_DIV2_LAST;
      unique case (lo)
         ASC_CLK_FAST: r = hi ? ASC_DIV4_LAST  : ASC_DIV2_LAST;
         ASC_CLK_MID:  r = hi ? ASC_DIV16_LAST : ASC_DIV8_LAST;
         ASC_CLK_SLOW: r = hi ? ASC_DIV64_LAST : ASC_DIV32_LAST;
         ASC_CLK_RC:   r = ASC_DIV2_LAST;
      endcase
      return r;
   endfunction

   // one bit per analog input pin, 7 down to 0, high where the pin is not digital
   function automatic logic [ASC_PIN_N-1:0] asc_analog_mask(input logic [3:0] cfg);
      logic [ASC_PIN_N-1:0] m;
      m = ASC_NONE_ANALOG;
      unique casez (cfg)
         4'h0, 4'h1, 4'h8:       m = 8'hFF;
         4'h2, 4'h3, 4'hC:       m = 8'h1F;
         4'h4, 4'h5:             m = 8'h0B;
         4'b011?:                m = ASC_NONE_ANALOG;
         4'h9, 4'hA, 4'hB:       m = 8'h3F;
         4'hD:                   m = 8'h0F;
         4'hE:                   m = 8'h01;
         4'hF:                   m = 8'h0D;
      endcase
      return m;
   endfunction

   // a negative reference from a pin always comes with a positive one from a pin
   function automatic logic asc_vref_neg_pin(input logic [3:0] cfg);
      return (cfg == 4'h8) || (cfg == 4'hB) || (cfg == 4'hC) || (cfg == 4'hD) ||
             (cfg == 4'hF);
   endfunction

   function automatic logic asc_vref_pos_pin(input logic [3:0] cfg);
      return (cfg == 4'h1) || (cfg == 4'h3) || (cfg == 4'h5) || (cfg == 4'hA) ||
             asc_vref_neg_pin(cfg);
   endfunction

   // justified result bytes
   function automatic logic [ASC_REG_W-1:0] asc_res_byte(input logic [ASC_RES_W-1:0] r,
                                                         input logic right, input logic high);
      logic [ASC_REG_W-1:0] b;
      if (right) begin
         b = high ? {6'h00, r[9:8]} : r[7:0];
      end else begin
         b = high ? r[9:2] : {r[1:0], 6'h00};
      end
      return b;
   endfunction

   // only the six mapped words answer without an error
   function automatic logic asc_mapped(input logic [ASC_ADDR_W-1:0] a);
      return a inside {ASC_OFF_CTRL0, ASC_OFF_CTRL1, ASC_OFF_RES_HI,
                       ASC_OFF_RES_LO, ASC_OFF_STATUS, ASC_OFF_PORT};
   endfunction

   // ========================================================================
   // state
   typedef struct packed {
      // sequencer
      asc_state_t                st;
      // software configuration
      asc_ctrl0_t                c0;
      asc_ctrl1_t                c1;
      // conversion timing, trial code and flags
      logic [ASC_DIV_W-1:0]      div_cnt;
      logic [ASC_TAD_W-1:0]      conversion_bit_period;
      logic [ASC_BIT_W-1:0]      bitpos;
      logic [ASC_RES_W-1:0]      sar;
      logic                      sample;
      logic                      done;
      // pin and reference steering
      logic [ASC_PIN_N-1:0]      amask;
      logic                      vpos;
      logic                      vneg;
      // bus answer
      logic                      pready;
      logic                      pslverr;
      logic [ASC_DATA_W-1:0]     prdata;
   } asc_regs_t;

   // registered state and its next value
   asc_regs_t                 s_r;
   asc_regs_t                 s_nxt;
   // conversion and bus helpers
   logic [ASC_RES_W-1:0]      result_r;
   logic                      load_result;
   logic                      tad_tick;
   logic                      rc_sel;
   logic                      wr_commit;
   logic                      rd_decode;
   logic [ASC_REG_W-1:0]      rd_byte;
   asc_ctrl0_t                wr_c0;

   // ========================================================================
   // conversion clock: divided bus clock, or RC ticks
   always_comb begin
      // the rc source already ticks once per bit period, so it skips the divider
      rc_sel = (s_r.c0.clock_divider_low_bits == ASC_CLK_RC);
      if (rc_sel) begin
         tad_tick = rc_tad_tick;
      end else begin
         // the bus clock is treated as stopped in sleep, so only RC advances
         tad_tick = !sleep_mode &&
                    (s_r.div_cnt == asc_div_last(s_r.c1.clock_divider_high_bit,
                                                 s_r.c0.clock_divider_low_bits));
      end
   end

   // ========================================================================
   // bus decode helpers
   // map: 00 primary, 04 secondary, 08 result high, 0C result low,
   // 10 done flag (write one to clear), 14 pin readout; data in the low byte
   always_comb begin
      wr_commit = psel && penable && s_r.pready && pwrite;
      rd_decode = psel && penable && !s_r.pready;
      wr_c0     = asc_ctrl0_t'(pwdata[ASC_REG_W-1:0]);
      rd_byte   = '0;
      unique case (paddr)
         ASC_OFF_CTRL0: begin
            rd_byte = s_r.c0;
            rd_byte[1] = 1'b0;
         end
         ASC_OFF_CTRL1: begin
            rd_byte = s_r.c1;
            rd_byte[5:4] = 2'h0;
         end
         ASC_OFF_RES_HI: begin
            rd_byte = asc_res_byte(result_r, s_r.c1.result_justify_select, 1'b1);
         end
         ASC_OFF_RES_LO: begin
            rd_byte = asc_res_byte(result_r, s_r.c1.result_justify_select, 1'b0);
         end
         ASC_OFF_STATUS: begin
            rd_byte[ASC_STAT_DONE] = s_r.done;
         end
         ASC_OFF_PORT: begin
            rd_byte = port_pin_level & ~s_r.amask;
         end
         default: begin
            rd_byte = '0;
         end
      endcase
   end

   // ========================================================================
   // next state: conversion sequencer, then software writes on top
   always_comb begin
      s_nxt       = s_r;
      load_result = 1'b0;

      // pin and reference steering follow the config field
      s_nxt.amask = asc_analog_mask(s_r.c1.pin_analog_config);
      s_nxt.vpos  = asc_vref_pos_pin(s_r.c1.pin_analog_config);
      s_nxt.vneg  = asc_vref_neg_pin(s_r.c1.pin_analog_config);

      // successive approximation over twelve bit periods
      if (s_r.st == ASC_CONV) begin
         // the divider holds in sleep, so a stalled conversion resumes mid-period
         if (tad_tick || rc_sel) begin
            s_nxt.div_cnt = '0;
         end else if (!sleep_mode) begin
            s_nxt.div_cnt = s_r.div_cnt + 1'b1;
         end
         if (tad_tick) begin
            s_nxt.conversion_bit_period = s_r.conversion_bit_period + 1'b1;
            if (s_r.conversion_bit_period == ASC_TAD_SAMPLE) begin
               // hold opens, first trial is half scale
               s_nxt.sample = 1'b0;
               s_nxt.sar    = '0;
               s_nxt.sar[ASC_BIT_MSB] = 1'b1;
               s_nxt.bitpos = ASC_BIT_MSB;
            end else if (s_r.conversion_bit_period == ASC_TAD_LAST) begin
               load_result     = 1'b1;
               s_nxt.st        = ASC_IDLE;
               s_nxt.c0.go_busy = 1'b0;
               s_nxt.done      = 1'b1;
               s_nxt.sample    = 1'b1;
            end else begin
               // keep the trial bit only if the input is at or above the trial level
               if (!comp_above) begin
                  s_nxt.sar[s_r.bitpos] = 1'b0;
               end
               // then try the next lower bit; after the lowest one nothing is raised
               if (s_r.bitpos != ASC_BIT_LSB) begin
                  s_nxt.sar[s_r.bitpos - 1'b1] = 1'b1;
                  s_nxt.bitpos = s_r.bitpos - 1'b1;
               end
            end
         end
      end

      // bus answer two cycles after the setup phase, one wait state
      s_nxt.pready  = rd_decode;
      s_nxt.pslverr = 1'b0;
      if (rd_decode) begin
         s_nxt.prdata  = {{(ASC_DATA_W-ASC_REG_W){1'b0}}, rd_byte};
         // an unmapped word answers with an error and zero data
         s_nxt.pslverr = !asc_mapped(paddr);
      end

      // software writes take effect at the edge that completes the access
      if (wr_commit) begin
         unique case (paddr)
            ASC_OFF_CTRL0: begin
               s_nxt.c0.clock_divider_low_bits = wr_c0.clock_divider_low_bits;
               s_nxt.c0.input_channel_select   = wr_c0.input_channel_select;
               s_nxt.c0.converter_power_on     = wr_c0.converter_power_on;
               if (!wr_c0.converter_power_on || !wr_c0.go_busy) begin
                  // clearing power or the start bit abandons the conversion
                  s_nxt.st         = ASC_IDLE;
                  s_nxt.c0.go_busy = 1'b0;
                  s_nxt.sample     = 1'b1;
               end else if (s_r.st == ASC_IDLE) begin
                  // a fresh start tracks the input until the first bit-period tick, one whole period on the divided clock
                  s_nxt.st         = ASC_CONV;
                  s_nxt.c0.go_busy = 1'b1;
                  s_nxt.div_cnt    = '0;
                  s_nxt.conversion_bit_period        = ASC_TAD_SAMPLE;
                  s_nxt.sample     = 1'b1;
               end else begin
                  // a repeated start leaves the running conversion alone
                  s_nxt.c0.go_busy = 1'b1;
               end
            end
            ASC_OFF_CTRL1: begin
               s_nxt.c1 = asc_ctrl1_t'(pwdata[ASC_REG_W-1:0]);
               s_nxt.c1.unused54 = 2'h0;
            end
            ASC_OFF_STATUS: begin
               // write one clears; a completion in the same cycle wins
               if (pwdata[ASC_STAT_DONE] && !load_result) begin
                  s_nxt.done = 1'b0;
               end
            end
            default: begin
               s_nxt.done = s_nxt.done;
            end
         endcase
      end
      s_nxt.c0.unused1 = 1'b0;
      // an unpowered converter never tracks its input
      if (!s_nxt.c0.converter_power_on) begin
         s_nxt.sample = 1'b0;
      end
   end

   // ========================================================================
   // state register: reset powers down, clears config, all pins analog
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r       <= '0;
         s_r.amask <= ASC_ALL_ANALOG;
      end else begin
         s_r <= s_nxt;
      end
   end

   // result pair has no reset so its contents survive a device reset
   // it sits outside the state struct because that struct is cleared by reset
   always_ff @(posedge pclk) begin
      if (load_result) begin
         result_r <= s_r.sar;
      end
   end

   // ========================================================================
   // outputs, all from flops
   assign prdata               = s_r.prdata;
   assign pready               = s_r.pready;
   assign pslverr              = s_r.pslverr;

   // converter side and pin steering
   assign converter_power_on   = s_r.c0.converter_power_on;
   assign input_channel_select = s_r.c0.input_channel_select;
   assign sample_hold_en       = s_r.sample;
   assign sar_trial_code       = s_r.sar;
   assign vref_pos_from_pin    = s_r.vpos;
   assign vref_neg_from_pin    = s_r.vneg;
   assign pin_analog_mask      = s_r.amask;
   assign conversion_busy      = s_r.c0.go_busy;
   assign conversion_done_flag = s_r.done;

endmodule

// File: rtl/asc_pkg.sv
// package for the successive-approximation converter control block: map, layouts, timing
package asc_pkg;

   // ========================================================================
   // widths and counts
   localparam int ASC_ADDR_W = 8;
   localparam int ASC_DATA_W = 32;
   localparam int ASC_REG_W  = 8;
   localparam int ASC_RES_W  = 10;
   localparam int ASC_PIN_N  = 8;
   localparam int ASC_DIV_W  = 6;
   localparam int ASC_TAD_W  = 4;
   localparam int ASC_BIT_W  = 4;

   // ========================================================================
   // register byte offsets on the bus
   localparam logic [ASC_ADDR_W-1:0] ASC_OFF_CTRL0  = 8'h00;
   localparam logic [ASC_ADDR_W-1:0] ASC_OFF_CTRL1  = 8'h04;
   localparam logic [ASC_ADDR_W-1:0] ASC_OFF_RES_HI = 8'h08;
   localparam logic [ASC_ADDR_W-1:0] ASC_OFF_RES_LO = 8'h0C;
   localparam logic [ASC_ADDR_W-1:0] ASC_OFF_STATUS = 8'h10;
   localparam logic [ASC_ADDR_W-1:0] ASC_OFF_PORT   = 8'h14;

   // ========================================================================
   // conversion timing, counted in conversion bit periods
   localparam logic [ASC_TAD_W-1:0] ASC_TAD_SAMPLE = 4'h0;  // hold capacitor disconnects
   localparam logic [ASC_TAD_W-1:0] ASC_TAD_LAST   = 4'hB;  // twelfth period ends it
   localparam logic [ASC_BIT_W-1:0] ASC_BIT_MSB    = 4'h9;
   localparam logic [ASC_BIT_W-1:0] ASC_BIT_LSB    = 4'h0;

   // divider terminal counts (ratio minus one)
   localparam logic [ASC_DIV_W-1:0] ASC_DIV2_LAST  = 6'h01;
   localparam logic [ASC_DIV_W-1:0] ASC_DIV4_LAST  = 6'h03;
   localparam logic [ASC_DIV_W-1:0] ASC_DIV8_LAST  = 6'h07;
   localparam logic [ASC_DIV_W-1:0] ASC_DIV16_LAST = 6'h0F;
   localparam logic [ASC_DIV_W-1:0] ASC_DIV32_LAST = 6'h1F;
   localparam logic [ASC_DIV_W-1:0] ASC_DIV64_LAST = 6'h3F;

   // low clock-select codes
   localparam logic [1:0] ASC_CLK_FAST = 2'h0;
   localparam logic [1:0] ASC_CLK_MID  = 2'h1;
   localparam logic [1:0] ASC_CLK_SLOW = 2'h2;
   localparam logic [1:0] ASC_CLK_RC   = 2'h3;

   localparam logic [ASC_PIN_N-1:0] ASC_ALL_ANALOG = 8'hFF;
   localparam logic [ASC_PIN_N-1:0] ASC_NONE_ANALOG = 8'h00;
   localparam int ASC_STAT_DONE = 0;

   // ========================================================================
   // register layouts and state
   typedef struct packed {
      logic [1:0] clock_divider_low_bits;
      logic [2:0] input_channel_select;
      logic       go_busy;
      logic       unused1;
      logic       converter_power_on;
   } asc_ctrl0_t;

   typedef struct packed {
      logic       result_justify_select;
      logic       clock_divider_high_bit;
      logic [1:0] unused54;
      logic [3:0] pin_analog_config;
   } asc_ctrl1_t;

   typedef enum logic {ASC_IDLE, ASC_CONV} asc_state_t;

endpackage

// File: dv/asc_analog_model.sv
// behavioural sample-and-hold and comparator on the converter's analog side
`timescale 1ns/1ps

module asc_analog_model
   import asc_pkg::*;
(
   input  wire logic                          pclk,
   input  wire logic [79:0]                   an_level,
   input  wire logic [2:0]                    input_channel_select,
   input  wire logic                          sample_hold_en,
   input  wire logic [asc_pkg::ASC_RES_W-1:0] sar_trial_code,
   output logic                               comp_above
);
   logic [ASC_RES_W-1:0] held_r;

   // ========
   // track the routed pin while sampling; once the switch opens the charge is frozen
   always @(posedge pclk) begin
      if (sample_hold_en) begin
         held_r <= an_level[int'(input_channel_select)*10 +: 10];
      end
   end

   // comparator: high while the held level is at or above the trial code
   assign comp_above = (held_r >= sar_trial_code);
endmodule

// File: dv/asc_adc_sar_control_assertions.sv
// assertion checker for the converter control block, bound to its ports
`timescale 1ns/1ps

module asc_adc_sar_control_assertions
   import asc_pkg::*;
(
   input wire logic                          pclk,
   input wire logic                          presetn,
   input wire logic                          psel,
   input wire logic                          penable,
   input wire logic                          pwrite,
   input wire logic [asc_pkg::ASC_ADDR_W-1:0] paddr,
   input wire logic [asc_pkg::ASC_DATA_W-1:0] pwdata,
   input wire logic                          pready,
   input wire logic                          converter_power_on,
   input wire logic                          sample_hold_en,
   input wire logic [asc_pkg::ASC_RES_W-1:0] sar_trial_code,
   input wire logic                          vref_pos_from_pin,
   input wire logic                          vref_neg_from_pin,
   input wire logic [asc_pkg::ASC_PIN_N-1:0] pin_analog_mask,
   input wire logic                          conversion_busy,
   input wire logic                          conversion_done_flag
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ========
   // bus writes as the slave commits them
   wire logic wr_hit  = psel && penable && pready && pwrite;
   wire logic wr_ctl0 = wr_hit && (paddr == ASC_OFF_CTRL0);
   wire logic wr_stat = wr_hit && (paddr == ASC_OFF_STATUS) && pwdata[ASC_STAT_DONE];
   wire logic wr_pwr  = pwdata[0];
   wire logic wr_go   = pwdata[2];

   // ========
   // rules
   reset_state_a: assert property (
      $rose(presetn) |-> pin_analog_mask == 8'hFF && !conversion_busy && !converter_power_on)
      else $error("state after reset is wrong");
   start_go_a: assert property (
      wr_ctl0 && wr_pwr && wr_go && !conversion_busy |=> conversion_busy)
      else $error("start write did not start a conversion");
   start_off_a: assert property (wr_ctl0 && !wr_pwr |=> !conversion_busy)
      else $error("conversion runs while powered off");
   power_bit_a: assert property (wr_ctl0 |=> converter_power_on == $past(wr_pwr))
      else $error("power output does not follow the power bit");
   busy_power_a: assert property (conversion_busy |-> converter_power_on)
      else $error("busy without power");
   done_sets_a: assert property (
      $fell(conversion_busy) && !$past(wr_hit) |-> conversion_done_flag && sample_hold_en)
      else $error("completion did not set the done flag");
   done_sticky_a: assert property (conversion_done_flag && !wr_stat |=> conversion_done_flag)
      else $error("done flag dropped without a clear");
   first_trial_a: assert property (
      $fell(sample_hold_en) && conversion_busy |-> sar_trial_code == 10'h200)
      else $error("first trial code is not mid-scale");
   sample_first_a: assert property ($rose(conversion_busy) |-> sample_hold_en)
      else $error("hold opened at start of conversion");
   vref_pair_a: assert property (vref_neg_from_pin |-> vref_pos_from_pin)
      else $error("negative reference pin without positive one");

   cover property ($fell(conversion_busy) && conversion_done_flag);
   cover property (wr_stat);
   cover property ($rose(conversion_busy) ##[1:800] $fell(conversion_busy));
endmodule

bind asc_adc_sar_control asc_adc_sar_control_assertions u_asc_adc_sar_control_assertions (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .converter_power_on,
   .sample_hold_en, .sar_trial_code, .vref_pos_from_pin, .vref_neg_from_pin, .pin_analog_mask,
   .conversion_busy, .conversion_done_flag);

// File: dv/asc_adc_sar_control_tb.sv
// self-checking bench for the converter control block and its analog partner
`timescale 1ns/1ps

module asc_adc_sar_control_tb;
   import asc_pkg::*;

   // ========
   // signals and bench state
   logic        pclk           = 1'b0;
   logic        presetn        = 1'b0;
   logic        psel           = 1'b0;
   logic        penable        = 1'b0;
   logic        pwrite         = 1'b0;
   logic [7:0]  paddr          = 8'h00;
   logic [31:0] pwdata         = 32'h0;
   logic        rc_tad_tick    = 1'b0;
   logic        sleep_mode     = 1'b0;
   logic [7:0]  port_pin_level = 8'h5A;
   logic [79:0] an_level       = {10'h3FF, 10'h2AB, 10'h155, 10'h200,
                                  10'h1FF, 10'h001, 10'h000, 10'h0C3};
   logic [31:0] prdata, q;
   logic [9:0]  sar_trial_code, last_v;
   logic [7:0]  pin_analog_mask;
   logic [2:0]  input_channel_select;
   logic        pready, pslverr, comp_above, converter_power_on, sample_hold_en;
   logic        q_err;
   logic        vref_pos_from_pin, vref_neg_from_pin, conversion_busy, conversion_done_flag;
   int          miscompares = 0;
   int          n_compared  = 0;
   int          rc_div      = 0;
   int          n, t;
   localparam logic [7:0]  AMASK [16] = '{8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'h0B, 8'h0B, 8'h00,
      8'h00, 8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'h1F, 8'h0F, 8'h01, 8'h0D};
   localparam logic [15:0] VPOS = 16'hBD2A;
   localparam logic [15:0] VNEG = 16'hB900;

   // ========
   // clock, rc ticks, design and partner
   always #25 pclk = ~pclk;

   // the rc source runs free, so its phase against a start is arbitrary
   always @(posedge pclk) begin
      rc_div      <= (rc_div == 4) ? 0 : rc_div + 1;
      rc_tad_tick <= (rc_div == 4);
   end

   asc_adc_sar_control u_asc_adc_sar_control (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .comp_above, .rc_tad_tick, .sleep_mode,
      .port_pin_level, .converter_power_on, .input_channel_select, .sample_hold_en,
      .sar_trial_code, .vref_pos_from_pin, .vref_neg_from_pin, .pin_analog_mask,
      .conversion_busy, .conversion_done_flag);

   asc_analog_model u_asc_analog_model (.pclk, .an_level, .input_channel_select,
      .sample_hold_en, .sar_trial_code, .comp_above);

   // ========
   // comparison and bus tasks
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one transfer; the request stands until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q     = prdata;
      q_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk_val(q, exp);
   endtask

   // counts busy cycles and rc ticks until the conversion ends, bounded
   task automatic wait_idle;
      n = 0;
      t = 0;
      @(negedge pclk);
      while (conversion_busy === 1'b1 && n < 2000) begin
         n++;
         t += int'(rc_tad_tick);
         @(negedge pclk);
      end
      if (n >= 2000) miscompares++;
   endtask

   // ========
   // scenarios
   task automatic t_reset;
      rd(ASC_OFF_CTRL0, 32'h0);
      rd(ASC_OFF_CTRL1, 32'h0);
      chk_val(pin_analog_mask, 8'hFF);
      rd(8'h40, 32'h0);
      chk_val(q_err, 1'b1);
   endtask

   task automatic t_reserved;
      wr(ASC_OFF_CTRL0, 32'hFE);
      rd(ASC_OFF_CTRL0, 32'hF8);
      wr(ASC_OFF_CTRL1, 32'hFF);
      rd(ASC_OFF_CTRL1, 32'hCF);
   endtask

   task automatic t_pins;
      for (int c = 0; c < 16; c++) begin
         wr(ASC_OFF_CTRL1, c);
         repeat (2) @(negedge pclk);
         chk_val(pin_analog_mask, AMASK[c]);
         chk_val(vref_pos_from_pin, VPOS[c]);
         chk_val(vref_neg_from_pin, VNEG[c]);
         rd(ASC_OFF_PORT, port_pin_level & ~AMASK[c]);
      end
   endtask

   // one full conversion with the given clock choice, channel and justification
   task automatic conv(input logic hi, input logic [1:0] lo, input logic [2:0] ch,
                       input logic rj, input int exp);
      logic [9:0] v;
      v = an_level[int'(ch)*10 +: 10];
      last_v = v;
      wr(ASC_OFF_CTRL1, {rj, hi, 6'h00});
      wr(ASC_OFF_CTRL0, {lo, ch, 3'b101});
      wait_idle;
      chk_val(input_channel_select, ch);
      chk_cnt((lo == 2'h3) ? t : n, exp);
      chk_val(conversion_done_flag, 1'b1);
      rd(ASC_OFF_CTRL0, {lo, ch, 3'b001});
      rd(ASC_OFF_RES_HI, rj ? {6'h00, v[9:8]} : v[9:2]);
      rd(ASC_OFF_RES_LO, rj ? v[7:0] : {v[1:0], 6'h00});
      chk_val(conversion_done_flag, 1'b1);
      wr(ASC_OFF_STATUS, 32'h1);
      @(negedge pclk);
      chk_val(conversion_done_flag, 1'b0);
      repeat (130) @(posedge pclk);
   endtask

   // channels 5 to 7 are used as on the full-size part
   task automatic t_clocks;
      conv(1'b0, 2'h0, 3'h0, 1'b1, 24);
      conv(1'b0, 2'h1, 3'h1, 1'b0, 96);
      conv(1'b0, 2'h2, 3'h2, 1'b1, 384);
      conv(1'b1, 2'h0, 3'h3, 1'b0, 48);
      conv(1'b1, 2'h1, 3'h4, 1'b1, 192);
      conv(1'b1, 2'h2, 3'h5, 1'b0, 768);
      conv(1'b1, 2'h3, 3'h6, 1'b1, 12);
   endtask

   task automatic t_sleep;
      sleep_mode <= 1'b1;
      conv(1'b0, 2'h3, 3'h7, 1'b0, 12);
      wr(ASC_OFF_CTRL1, 32'h0);
      wr(ASC_OFF_CTRL0, 32'h05);
      last_v = an_level[9:0];
      repeat (100) @(negedge pclk);
      chk_val(conversion_busy, 1'b1);
      @(posedge pclk);
      sleep_mode <= 1'b0;
      wait_idle;
      chk_val(conversion_done_flag, 1'b1);
      wr(ASC_OFF_STATUS, 32'h1);
   endtask

   task automatic t_abort;
      wr(ASC_OFF_CTRL1, 32'h46);
      wr(ASC_OFF_CTRL0, 32'h85);
      repeat (50) @(posedge pclk);
      wr(ASC_OFF_CTRL0, 32'h80);
      @(negedge pclk);
      chk_val({conversion_busy, converter_power_on, conversion_done_flag}, 3'h0);
      wr(ASC_OFF_CTRL0, 32'h85);
      repeat (50) @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk_val({conversion_busy, pin_analog_mask}, 9'h0FF);
      rd(ASC_OFF_CTRL0, 32'h0);
      rd(ASC_OFF_RES_HI, last_v[9:2]);
   endtask

   // ========
   // closing and main sequence
   task automatic wrap_up;
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_reserved;
      t_pins;
      t_clocks;
      t_sleep;
      t_abort;
      wrap_up;
   end

   // watchdog well beyond the roughly three and a half thousand cycles the run needs
   initial begin
      #2_000_000;
      miscompares++;
      wrap_up;
   end
endmodule
